/* hw/por_seq_cfg.svh */
/*
 reset sequencer constants: register addresses, reset values, counts.
 assumes inclusion from the package file and the testbench.
*/
`ifndef POR_SEQ_CFG_SVH
`define POR_SEQ_CFG_SVH
`define ADDR_STACK_LOW 8'hff
`define ADDR_REG_PTR 8'hfd
`define ADDR_INT_MASK 8'hfb
`define ADDR_INT_REQ 8'hfa
`define ADDR_TIMER_MODE 8'hf1
`define ADDR_STAT 8'he0
`define RST_ZERO 8'h00
`define INT_REQ_KEEP 8'hc0
`define INT_MASK_KEEP 8'h7f
`define START_VECTOR 16'h000c
`define EXTRA_CYCLES 5'd18
`define POR_RC_TICKS 16'd1000
`define DOG_RC_TICKS 16'd500
`define RC_DIV 16'd100
`endif

/* hw/por_seq_pkg.sv */
/*
 types of the reset sequencer.
 assumes por_seq_cfg.svh is on the include path.
*/
`include "por_seq_cfg.svh"
package por_seq_pkg;
    typedef enum logic [1:0] {st_oneshot, st_extra, st_run} seq_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic [7:0] stack_low;
        logic [7:0] reg_ptr;
        logic [7:0] int_mask;
        logic [7:0] int_req;
        logic [7:0] timer_mode;
    } ctrl_regs_t;
endpackage

/* hw/rc_oneshot.sv */
/*
 one-shot down counter ticking on the rc oscillator enable.
 assumes tick is a single-cycle enable in the core_clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module rc_oneshot #(
    parameter logic [15:0] TICKS = 16'd1000
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic start,
    input wire logic enable,
    output logic expired,
    output logic running
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    wire logic at_end = (cnt_r == 16'h0000);
    // start reloads the count, so this is retriggerable
    assign cnt_nxt = start ? TICKS : ((tick && !at_end) ? cnt_r - 16'h0001 : cnt_r);
    assign running = !at_end && enable;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_r <= 16'h0000;
            expired <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            expired <= enable && tick && !start && (cnt_r == 16'h0001);
        end
    end
endmodule
`default_nettype wire

/* hw/por_seq.sv */
/*
 power-on reset sequencer: por one-shot, watchdog, extra-cycle delay,
 control register reset values and a small register port.
 assumes power_good, stop_recovery_pin, halt_mode are async pins; rc_tick
 stands in for the on-chip rc oscillator as an enable in core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module por_seq
    import por_seq_pkg::*;
#(
    parameter logic [15:0] POR_TICKS = `POR_RC_TICKS,
    parameter logic [15:0] DOG_TICKS = `DOG_RC_TICKS,
    parameter logic [15:0] RC_DIVIDE = `RC_DIV
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic power_good,
    input wire logic stop_recovery_pin,
    input wire logic halt_mode,
    input wire logic watchdog_instr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic core_reset,
    output logic fetch_start,
    output logic [15:0] fetch_addr,
    output logic edge_interrupt_source_three
);
    reg_req_t req;
    ctrl_regs_t regs_r;
    seq_state_t state_r;
    logic [1:0] pg_sync_r, stop_sync_r, halt_sync_r;
    logic pg_prev_r, stop_prev_r;
    logic [15:0] rc_div_r;
    logic [4:0] extra_r;
    logic dog_en_r, full_reset_r, por_started_r;
    logic por_exp, por_run, dog_exp, dog_run;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // pins cross into core_clk through two flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pg_sync_r <= 2'b00;
            stop_sync_r <= 2'b00;
            halt_sync_r <= 2'b00;
        end else begin
            pg_sync_r <= {pg_sync_r[0], power_good};
            stop_sync_r <= {stop_sync_r[0], stop_recovery_pin};
            halt_sync_r <= {halt_sync_r[0], halt_mode};
        end
    end
    wire logic pg_s = pg_sync_r[1];
    wire logic stop_s = stop_sync_r[1];
    wire logic halt_s = halt_sync_r[1];
    wire logic pg_rise = pg_s && !pg_prev_r;
    wire logic stop_rise = stop_s && !stop_prev_r;

    // rc oscillator modelled as a divider enable; independent of the core state
    wire logic rc_tick = (rc_div_r == 16'h0000);
    always_ff @(posedge core_clk) begin
        if (reset || rc_tick) begin
            rc_div_r <= RC_DIVIDE - 16'h0001;
        end else begin
            rc_div_r <= rc_div_r - 16'h0001;
        end
    end

    // a stale expiry left over after disable must not reset the device
    wire logic dog_fire = dog_exp && dog_en_r;
    wire logic dog_timeout = dog_fire && !halt_s;
    wire logic halt_dog_timeout = dog_fire && halt_s;
    // four triggers of the one-shot
    wire logic por_trigger = pg_rise || stop_rise || dog_timeout || halt_dog_timeout;
    // full reset comes from power or watchdog only; stop pin is a recovery
    wire logic full_trigger = pg_rise || dog_fire;
    wire logic dog_start = watchdog_instr && (state_r == st_run);

    rc_oneshot #(.TICKS(POR_TICKS)) u_por (
        .core_clk(core_clk),
        .reset(reset),
        .tick(rc_tick),
        .start(por_trigger),
        .enable(1'b1),
        .expired(por_exp),
        .running(por_run)
    );

    // watchdog on rc ticks; the instruction both enables and retriggers
    rc_oneshot #(.TICKS(DOG_TICKS)) u_dog (
        .core_clk(core_clk),
        .reset(reset),
        .tick(rc_tick),
        .start(dog_start),
        .enable(dog_en_r),
        .expired(dog_exp),
        .running(dog_run)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pg_prev_r <= 1'b0;
            stop_prev_r <= 1'b0;
            state_r <= st_oneshot;
            extra_r <= 5'd0;
            dog_en_r <= 1'b0;
            full_reset_r <= 1'b1;
            por_started_r <= 1'b0;
        end else begin
            pg_prev_r <= pg_s;
            stop_prev_r <= stop_s;
            if (por_trigger) begin
                state_r <= st_oneshot;
                por_started_r <= 1'b1;
                dog_en_r <= 1'b0;
                if (full_trigger) begin
                    full_reset_r <= 1'b1;
                end
            end else begin
                case (state_r)
                    st_oneshot: begin
                        if (por_exp && por_started_r) begin
                            state_r <= st_extra;
                            extra_r <= 5'd0;
                        end
                    end
                    st_extra: begin
                        extra_r <= extra_r + 5'd1;
                        if (extra_r == `EXTRA_CYCLES - 5'd1) begin
                            state_r <= st_run;
                            full_reset_r <= 1'b0;
                        end
                    end
                    default: begin
                        if (watchdog_instr) begin
                            dog_en_r <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign core_reset = (state_r != st_run);
    assign fetch_start = (state_r == st_extra) && (extra_r == `EXTRA_CYCLES - 5'd1);
    assign fetch_addr = `START_VECTOR;
    assign edge_interrupt_source_three = 1'b1;

    // control registers; loaded only while a full reset is pending
    wire logic apply_defaults = full_reset_r;
    wire logic sw_wr = req.wr && (state_r == st_run);
    always_ff @(posedge core_clk) begin
        if (reset || apply_defaults) begin
            regs_r.stack_low <= `RST_ZERO;
            regs_r.reg_ptr <= `RST_ZERO;
            regs_r.timer_mode <= `RST_ZERO;
            regs_r.int_mask <= regs_r.int_mask & `INT_MASK_KEEP;
            regs_r.int_req <= regs_r.int_req & `INT_REQ_KEEP;
        end else if (sw_wr) begin
            if (req.addr == `ADDR_STACK_LOW) begin
                regs_r.stack_low <= req.wdata;
            end else if (req.addr == `ADDR_REG_PTR) begin
                regs_r.reg_ptr <= req.wdata;
            end else if (req.addr == `ADDR_INT_MASK) begin
                regs_r.int_mask <= req.wdata;
            end else if (req.addr == `ADDR_INT_REQ) begin
                regs_r.int_req <= req.wdata;
            end else if (req.addr == `ADDR_TIMER_MODE) begin
                regs_r.timer_mode <= req.wdata;
            end
        end
    end

    logic [7:0] rd_mux;
    wire logic [7:0] stat_word = {3'b000, dog_run, dog_en_r, por_run, state_r};
    always_comb begin
        if (req.addr == `ADDR_STACK_LOW) begin
            rd_mux = regs_r.stack_low;
        end else if (req.addr == `ADDR_REG_PTR) begin
            rd_mux = regs_r.reg_ptr;
        end else if (req.addr == `ADDR_INT_MASK) begin
            rd_mux = regs_r.int_mask;
        end else if (req.addr == `ADDR_INT_REQ) begin
            rd_mux = regs_r.int_req;
        end else if (req.addr == `ADDR_TIMER_MODE) begin
            rd_mux = regs_r.timer_mode;
        end else if (req.addr == `ADDR_STAT) begin
            rd_mux = stat_word;
        end else begin
            rd_mux = 8'h00;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else begin
            rdata <= req.rd ? rd_mux : 8'h00;
        end
    end

    property p_extra_release;
        @(posedge core_clk) disable iff (reset)
        (state_r == st_oneshot && por_exp && por_started_r && !por_trigger)
            |=> (core_reset [*8]) ##0 1'b1;
    endproperty
    a_extra_release: assert property (p_extra_release) else $error("released early");

    property p_reset_regs;
        @(posedge core_clk) disable iff (reset)
        (state_r == st_extra && full_reset_r)
            |=> (regs_r.stack_low == 8'h00 && regs_r.reg_ptr == 8'h00 && !regs_r.int_mask[7]);
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("regs not reset");

    property p_irq_low;
        @(posedge core_clk) disable iff (reset)
        (state_r == st_extra && full_reset_r)
            |=> (regs_r.int_req[5:0] == 6'h00 && regs_r.timer_mode == 8'h00);
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq not cleared");

    property p_stop_keep;
        @(posedge core_clk) disable iff (reset)
        (!full_reset_r && !full_trigger && !sw_wr) |=> $stable(regs_r);
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("regs changed");

    property p_trigger_restarts;
        @(posedge core_clk) disable iff (reset)
        por_trigger |=> (state_r == st_oneshot && core_reset);
    endproperty
    a_trigger_restarts: assert property (p_trigger_restarts) else $error("no restart");

    property p_dog_off;
        @(posedge core_clk) disable iff (reset)
        !dog_en_r |-> !dog_fire;
    endproperty
    a_dog_off: assert property (p_dog_off) else $error("watchdog fired disabled");

    property p_dog_reset;
        @(posedge core_clk) disable iff (reset)
        dog_fire |=> (core_reset && full_reset_r);
    endproperty
    a_dog_reset: assert property (p_dog_reset) else $error("watchdog no reset");

    property p_dog_restart;
        @(posedge core_clk) disable iff (reset)
        dog_start |=> !dog_exp;
    endproperty
    a_dog_restart: assert property (p_dog_restart) else $error("refresh not honoured");

    property p_stop_no_defaults;
        @(posedge core_clk) disable iff (reset)
        (stop_rise && !full_trigger && !full_reset_r) |=> !full_reset_r;
    endproperty
    a_stop_no_defaults: assert property (p_stop_no_defaults) else $error("stop reloaded");

    property p_oneshot_holds;
        @(posedge core_clk) disable iff (reset)
        por_run |-> core_reset;
    endproperty
    a_oneshot_holds: assert property (p_oneshot_holds) else $error("core ran early");

    property p_release_after_fetch;
        @(posedge core_clk) disable iff (reset)
        $fell(core_reset) |-> $past(fetch_start);
    endproperty
    a_release_after_fetch: assert property (p_release_after_fetch) else $error("no fetch");

    property p_full_marks;
        @(posedge core_clk) disable iff (reset)
        full_trigger |=> full_reset_r;
    endproperty
    a_full_marks: assert property (p_full_marks) else $error("full reset lost");

    property p_extra_bound;
        @(posedge core_clk) disable iff (reset)
        (state_r == st_extra) |-> (extra_r < `EXTRA_CYCLES);
    endproperty
    a_extra_bound: assert property (p_extra_bound) else $error("extra overrun");

    property p_run_fetch;
        @(posedge core_clk) disable iff (reset)
        fetch_start && !por_trigger |=> (!core_reset && fetch_addr == 16'h000c);
    endproperty
    a_run_fetch: assert property (p_run_fetch) else $error("bad fetch");
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/*
 self-checking bench for the reset sequencer: boot, registers, stop pin, watchdog.
 assumes por_seq_pkg compiled first and por_seq_cfg.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "por_seq_cfg.svh"
module tb_top
    import por_seq_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic power_good = 1'b0;
    logic stop_recovery_pin = 1'b0;
    logic halt_mode = 1'b0;
    logic watchdog_instr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] rdata;
    logic core_reset;
    logic fetch_start;
    logic edge_interrupt_source_three;
    logic [15:0] fetch_addr;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [7:0] rnd = 8'h06;
    logic [7:0] regs [5] = '{`ADDR_STACK_LOW, `ADDR_REG_PTR, `ADDR_INT_MASK, `ADDR_INT_REQ,
        `ADDR_TIMER_MODE};
    logic [7:0] vals [5];
    int n_fail = 0;
    int check_count = 0;

    always #5 core_clk = ~core_clk;

    // short counts so a full boot takes tens of cycles
    por_seq #(.POR_TICKS(16'd4), .DOG_TICKS(16'd3), .RC_DIVIDE(16'd2)) por_seq_inst (
        .core_clk(core_clk), .reset(reset), .power_good(power_good),
        .stop_recovery_pin(stop_recovery_pin), .halt_mode(halt_mode),
        .watchdog_instr(watchdog_instr), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .core_reset(core_reset), .fetch_start(fetch_start),
        .fetch_addr(fetch_addr), .edge_interrupt_source_three(edge_interrupt_source_three)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data counts only in the cycle after the strobe, zero elsewhere
    always @(posedge core_clk) rd_seen <= rd;
    always @(negedge core_clk) begin
        if (rd_seen && exp_q.size() == 0) begin
            chk_flag(1'b0, 1'b1);
        end else if (rd_seen) begin
            e = exp_q.pop_front();
            chk_val({8'h00, rdata & e[15:8]}, {8'h00, e[7:0] & e[15:8]});
        end else begin
            chk_val({8'h00, rdata}, 16'h0000);
        end
    end

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({m, x});
        @(posedge core_clk);
        rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic pulse_instr;
        @(posedge core_clk);
        watchdog_instr <= 1'b1;
        @(posedge core_clk);
        watchdog_instr <= 1'b0;
    endtask

    task automatic wait_rst(input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset !== 1'b1 && n < hi) begin
            @(negedge core_clk);
            n++;
        end
        chk_flag(core_reset === 1'b1 && n >= lo, 1'b1);
        if (core_reset !== 1'b1) conclude();
    endtask

    // lower bound leaves room for rc tick phase and sync delay
    task automatic wait_boot;
        int n;
        n = 0;
        @(negedge core_clk);
        while (fetch_start !== 1'b1 && n < 60) begin
            chk_flag(core_reset, 1'b1);
            @(negedge core_clk);
            n++;
        end
        chk_flag(fetch_start, 1'b1);
        if (fetch_start !== 1'b1) conclude();
        chk_flag(n >= 20 && n <= 40, 1'b1);
        chk_val(fetch_addr, `START_VECTOR);
        @(negedge core_clk);
        chk_flag(core_reset, 1'b0);
    endtask

    task automatic chk_defaults;
        rd_reg(`ADDR_STACK_LOW, `RST_ZERO, 8'hff);
        rd_reg(`ADDR_REG_PTR, `RST_ZERO, 8'hff);
        rd_reg(`ADDR_TIMER_MODE, `RST_ZERO, 8'hff);
        rd_reg(`ADDR_INT_MASK, `RST_ZERO, ~`INT_MASK_KEEP);
        rd_reg(`ADDR_INT_REQ, `RST_ZERO, ~`INT_REQ_KEEP);
        // one-shot idle, watchdog off and idle after every boot
        rd_reg(`ADDR_STAT, 8'h00, 8'h1c);
        chk_flag(edge_interrupt_source_three, 1'b1);
    endtask

    task automatic write_rand;
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr_next(rnd);
            vals[i] = rnd;
            wr_reg(regs[i], rnd);
        end
    endtask

    task automatic read_back;
        for (int i = 0; i < 5; i++) begin
            rd_reg(regs[i], vals[i], 8'hff);
        end
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        power_good <= 1'b1;
        wait_boot();
        chk_defaults();
        rd_reg(8'h10, 8'h00, 8'hff); // unmapped place reads zero
        write_rand();
        read_back();
        @(posedge core_clk);
        // bench has no port pins driven, so no contention on recovery
        stop_recovery_pin <= 1'b1;
        wait_rst(0, 8);
        // write while held must be dropped, so old contents survive
        wr_reg(`ADDR_STACK_LOW, ~vals[0]);
        stop_recovery_pin <= 1'b0;
        wait_boot();
        read_back();
        for (int h = 0; h < 2; h++) begin
            @(posedge core_clk);
            halt_mode <= h[0];
            write_rand();
            repeat (30) begin
                @(negedge core_clk);
                chk_flag(core_reset, 1'b0);
            end
            repeat (10) begin
                pulse_instr();
                @(negedge core_clk);
                chk_flag(core_reset, 1'b0);
            end
            pulse_instr();
            wait_rst(4, 12);
            wait_boot();
            chk_defaults();
            @(posedge core_clk);
            halt_mode <= 1'b0;
        end
        conclude();
    end
endmodule
`default_nettype wire
